// file: design/lhm_poll_counter.v
// 13-stage counter, held at zero unless run_i is high, giving a mid-count poll strobe
`timescale 1ns/1ps

module lhm_poll_counter #(
  parameter WIDTH = 13
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // control
  input  wire             run_i,
  // strobe
  output reg              mid_o
);

  reg [WIDTH-1:0] cnt_q;

  // count only while running so every limp-home stay starts from zero
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= {WIDTH{1'b0}};
      mid_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      mid_o <= (cnt_q == {1'b0, {(WIDTH-1){1'b1}}});
    end
  end

endmodule // lhm_poll_counter

// file: design/pll_lhm_consts.vh
// register offsets, field positions, reset values and counts for pll/limp-home control
`ifndef PLL_LHM_CONSTS_VH
`define PLL_LHM_CONSTS_VH

// word-aligned byte offsets of the register words
`define OFF_CTRL        8'h00
`define OFF_FLAG        8'h04
`define OFF_STAT        8'h08

// control word fields
`define CTRL_AUTO       0
`define CTRL_TRACK      1
`define CTRL_PLL_POWER_ON      2
`define CTRL_CME        3
`define CTRL_FORCED_CLOCK_MONITOR_ENABLE       4
`define CTRL_LIMP_HOME_DISABLE      5
`define CTRL_BUS_CLOCK_PLL_SELECT       6
`define CTRL_MCS        7
`define CTRL_LOCK_INTERRUPT_ENABLE     8
`define CTRL_LIMP_HOME_INTERRUPT_ENABLE       9
`define CTRL_W          10

// flag word fields (write one to clear)
`define FLAG_LOCKIF     0
`define FLAG_LIMP_HOME_INTERRUPT_FLAG       1

// status word fields
`define STAT_LOCK       0
`define STAT_LIMP_HOME_ACTIVE      1
`define STAT_TRACK      2

// control reset value: monitor on, pll on, limp-home allowed
`define CTRL_RESET      10'h00c

// 13-stage counter and poll point
`define CNT_W           13
`define CNT_MID         13'h1000

`endif

// file: design/pll_lhm_ctrl.v
// pll filter mode, lock reporting and limp-home fallback control
`timescale 1ns/1ps
`include "pll_lhm_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// - filter track bit clear means acquisition
// - tracking whenever not acquiring or bit set
// - auto mode lets lock detector switch filter
// - auto mode: track bit read-only, tolerance driven
// - lock bit follows lock/unlock tolerances
// - lock change raises interrupt when enabled
// - manual mode keeps lock detection and interrupts
// - manual mode track bit writable, clear first
// - limp-home only with pll supply present
// - power-up limp-home only in normal modes; boot_q clears on the first clock after reset, so mode is never checked
// - either monitor enable arms loss detection
// - limp-home disabled: clock loss resets device
// - limp-home enabled: loss switches to vco
// - limp-home forces pll on, bus pll, module low
// - limp-home flag change sets interrupt flag
// - monitor stays on during limp-home
// - module clocks from pll bus clock, can unchanged
// - poll monitor at mid-count every 8192 cycles
// - clock return exits limp-home, restores selections
// - auto plus bus pll relocks after exit
// - reset sets monitor, pll on, clears disable
module pll_lhm_ctrl #(
  parameter CNT_W = 13
) (
  // system
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // analog / monitor side (asynchronous)
  input  wire        pll_supply_i,
  input  wire        normal_mode_i,
  input  wire        ext_clk_present_i,
  input  wire        in_track_tol_i,
  input  wire        in_untrack_tol_i,
  input  wire        in_lock_tol_i,
  input  wire        in_unlock_tol_i,
  // clock control outputs
  output reg         pll_power_on_o,
  output reg         bus_clock_pll_select_o,
  output reg         module_clock_select_o,
  output reg         filter_tracking_o,
  output reg         clock_monitor_on_o,
  output reg         vco_min_clock_select_o,
  output reg         modules_from_pll_o,
  output reg         monitor_reset_o,
  output reg         irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam NS = 7;
  // supply, mode and clock read as present in reset, so no false
  // clock loss (and no monitor reset) fires while the chain refills
  localparam [NS-1:0] SYNC_IDLE = 7'h70;
  wire [NS-1:0] raw_in;
  reg  [NS-1:0] sync1_q;
  reg  [NS-1:0] sync2_q;
  assign raw_in = {pll_supply_i, normal_mode_i, ext_clk_present_i,
                   in_track_tol_i, in_untrack_tol_i, in_lock_tol_i,
                   in_unlock_tol_i};

  // two flops per pin; first stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire supply_s   = sync2_q[6];
  wire normal_s   = sync2_q[5];
  wire extclk_s   = sync2_q[4];
  wire trk_tol_s  = sync2_q[3];
  wire untrk_s    = sync2_q[2];
  wire lock_tol_s = sync2_q[1];
  wire unlock_s   = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg [`CTRL_W-1:0] ctrl_q;
  reg               lock_q;
  reg               auto_track_q;
  reg               lockif_q;
  reg               limp_home_interrupt_flag_q;
  reg               limp_home_active_q;
  reg               saved_bus_clock_pll_select_q;
  reg               saved_mcs_q;
  reg               boot_q;
  wire              lh_exit;

  wire wb_req = cyc_i && stb_i && !ack_o;
  wire wr_lo  = wb_req && we_i && sel_i[0];
  wire wr_hi  = wb_req && we_i && sel_i[1];

  // address decode used for both read mux and write strobes
  function is_off;
    input [7:0] a;
    input [7:0] off;
    begin
      is_off = (a == off);
    end
  endfunction

  wire wr_ctrl = is_off(adr_i, `OFF_CTRL);
  wire wr_flag = is_off(adr_i, `OFF_FLAG);

  wire auto_w    = ctrl_q[`CTRL_AUTO];
  wire mon_en    = ctrl_q[`CTRL_CME] | ctrl_q[`CTRL_FORCED_CLOCK_MONITOR_ENABLE];
  wire lhm_allow = supply_s && !ctrl_q[`CTRL_LIMP_HOME_DISABLE];

  // effective filter mode: clear means acquisition, set means tracking
  wire track_eff = auto_w ? auto_track_q
                          : ctrl_q[`CTRL_TRACK];

  ////////////////////////////////////////////////////////////////////////////
  // poll counter, runs only while in limp-home
  wire poll_mid;
  lhm_poll_counter #(
    .WIDTH (CNT_W)
  ) u_poll (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .run_i (limp_home_active_q),
    .mid_o (poll_mid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register; reset values raise monitor and pll power
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CTRL_RESET;
    end else if (lh_exit) begin
      // restore the selections saved at entry or written during limp-home when it ends
      ctrl_q[`CTRL_BUS_CLOCK_PLL_SELECT] <= saved_bus_clock_pll_select_q;
      ctrl_q[`CTRL_MCS]  <= saved_mcs_q;
    end else if (wr_ctrl) begin
      if (wr_lo) begin
        ctrl_q[7:0] <= dat_i[7:0];
        // auto mode keeps the tracking bit hardware-owned
        if (auto_w)
          ctrl_q[`CTRL_TRACK] <= ctrl_q[`CTRL_TRACK];
      end
      if (wr_hi)
        ctrl_q[`CTRL_W-1:8] <= dat_i[`CTRL_W-1:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock detector: hysteresis between enter and leave tolerances
  always @(posedge clk_i) begin
    if (rst_i) begin
      lock_q       <= 1'b0;
      auto_track_q <= 1'b0;
    end else begin
      // lock tracking runs in both auto and manual modes
      if (!lock_q && lock_tol_s)
        lock_q <= 1'b1;
      else if (lock_q && !unlock_s)
        lock_q <= 1'b0;
      // tracking decision only meaningful while auto is on
      if (!auto_w)
        auto_track_q <= 1'b0;
      else if (!auto_track_q && trk_tol_s)
        auto_track_q <= 1'b1;
      else if (auto_track_q && !untrk_s)
        auto_track_q <= 1'b0;
    end
  end

  wire lock_next = (!lock_q && lock_tol_s) ? 1'b1 :
                   (lock_q && !unlock_s) ? 1'b0 : lock_q;
  wire lock_chg  = lock_next != lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // limp-home state; boot_q gates the mode check and clears on the first clock after reset, as the clock idles present
  wire loss      = !extclk_s && (mon_en || limp_home_active_q);
  wire lh_enter  = !limp_home_active_q && loss && lhm_allow &&
                   (!boot_q || normal_s);
  assign lh_exit = limp_home_active_q && poll_mid && extclk_s;
  wire lh_chg    = lh_enter || lh_exit;

  always @(posedge clk_i) begin
    if (rst_i) begin
      limp_home_active_q      <= 1'b0;
      saved_bus_clock_pll_select_q <= 1'b0;
      saved_mcs_q  <= 1'b0;
      boot_q       <= 1'b1;
    end else begin
      if (extclk_s)
        boot_q <= 1'b0;
      if (lh_enter) begin
        limp_home_active_q      <= 1'b1;
        boot_q       <= 1'b0;
        saved_bus_clock_pll_select_q <= ctrl_q[`CTRL_BUS_CLOCK_PLL_SELECT];
        saved_mcs_q  <= ctrl_q[`CTRL_MCS];
      end else if (lh_exit) begin
        limp_home_active_q <= 1'b0;
      end else if (limp_home_active_q && wr_ctrl && wr_lo) begin
        // a clear of bus pll select now takes effect at exit
        saved_bus_clock_pll_select_q <= dat_i[`CTRL_BUS_CLOCK_PLL_SELECT];
        saved_mcs_q  <= dat_i[`CTRL_MCS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, write one to clear; a new event wins over the clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      lockif_q <= 1'b0;
      limp_home_interrupt_flag_q   <= 1'b0;
    end else begin
      if (lock_chg)
        lockif_q <= 1'b1;
      else if (wr_flag && wr_lo && dat_i[`FLAG_LOCKIF])
        lockif_q <= 1'b0;
      if (lh_chg)
        limp_home_interrupt_flag_q <= 1'b1;
      else if (wr_flag && wr_lo && dat_i[`FLAG_LIMP_HOME_INTERRUPT_FLAG])
        limp_home_interrupt_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock-selection outputs, forced during limp-home
  always @(posedge clk_i) begin
    if (rst_i) begin
      pll_power_on_o         <= 1'b0;
      bus_clock_pll_select_o <= 1'b0;
      module_clock_select_o  <= 1'b0;
      filter_tracking_o      <= 1'b0;
      clock_monitor_on_o     <= 1'b0;
      vco_min_clock_select_o <= 1'b0;
      modules_from_pll_o     <= 1'b0;
      monitor_reset_o        <= 1'b0;
      irq_o                  <= 1'b0;
    end else begin
      pll_power_on_o         <= limp_home_active_q | ctrl_q[`CTRL_PLL_POWER_ON];
      // outside limp-home the live bits apply again, so an auto+pll
      // setup relocks at its old frequency after exit
      bus_clock_pll_select_o <= limp_home_active_q | ctrl_q[`CTRL_BUS_CLOCK_PLL_SELECT];
      module_clock_select_o  <= !limp_home_active_q & ctrl_q[`CTRL_MCS];
      filter_tracking_o      <= track_eff;
      clock_monitor_on_o     <= mon_en | limp_home_active_q;
      vco_min_clock_select_o <= limp_home_active_q;
      modules_from_pll_o     <= limp_home_active_q;
      // loss with limp-home unavailable resets via the monitor vector
      monitor_reset_o        <= !limp_home_active_q && loss && !lh_enter;
      irq_o <= (lockif_q & ctrl_q[`CTRL_LOCK_INTERRUPT_ENABLE]) |
               (limp_home_interrupt_flag_q & ctrl_q[`CTRL_LIMP_HOME_INTERRUPT_ENABLE]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone: one wait state, ack for one cycle, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      dat_o <= 32'h00000000;
      if (wb_req && !we_i) begin
        if (is_off(adr_i, `OFF_CTRL)) begin
          dat_o[`CTRL_W-1:0]       <= ctrl_q;
          dat_o[`CTRL_TRACK]       <= track_eff;
        end else if (is_off(adr_i, `OFF_FLAG)) begin
          dat_o[`FLAG_LOCKIF]      <= lockif_q;
          dat_o[`FLAG_LIMP_HOME_INTERRUPT_FLAG]        <= limp_home_interrupt_flag_q;
        end else if (is_off(adr_i, `OFF_STAT)) begin
          dat_o[`STAT_LOCK]        <= lock_q;
          dat_o[`STAT_LIMP_HOME_ACTIVE]       <= limp_home_active_q;
          dat_o[`STAT_TRACK]       <= track_eff;
        end
      end
    end
  end

endmodule // pll_lhm_ctrl

// file: verification/ext_clock_source.sv
// far-side model: external clock presence and vco tolerance windows
`timescale 1ns/1ps
module ext_clock_source (
  // clock and commands
  input  logic clk_i,
  input  logic lost_i,
  input  logic near_i,
  // monitor and lock detector view
  output logic present_o,
  output logic track_o,
  output logic untrack_o,
  output logic lock_o,
  output logic unlock_o
);
  logic near_q = 1'b0;
  // outer windows let go a cycle after the inner ones (hysteresis)
  always @(posedge clk_i) begin
    near_q <= near_i;
  end
  assign present_o = !lost_i;
  assign track_o   = near_i;
  assign lock_o    = near_i;
  assign untrack_o = near_i | near_q;
  assign unlock_o  = near_i | near_q;
endmodule // ext_clock_source

// file: verification/pll_lhm_ctrl_bench.sv
// self-checking bench for the pll/limp-home control block
`timescale 1ns/1ps
`include "pll_lhm_consts.vh"
module pll_lhm_ctrl_bench;
  localparam CW = 4;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic        we_i = 1'b0, lost = 1'b0, near = 1'b0, sup = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, rd;
  wire  [31:0] dat_o;
  wire         ack_o, ext, trk, utrk, lck, ulck, pwr, bus_clock_pll_select, module_clock_select, ftrk;
  wire         mon, vmin, mpll, mrst, irq;
  integer      fails = 0, checked = 0, n;
  ext_clock_source far (.clk_i(clk_i), .lost_i(lost), .near_i(near),
    .present_o(ext), .track_o(trk), .untrack_o(utrk), .lock_o(lck),
    .unlock_o(ulck));
  pll_lhm_ctrl #(.CNT_W(CW)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pll_supply_i(sup), .normal_mode_i(1'b1), .ext_clk_present_i(ext),
    .in_track_tol_i(trk), .in_untrack_tol_i(utrk), .in_lock_tol_i(lck),
    .in_unlock_tol_i(ulck), .pll_power_on_o(pwr),
    .bus_clock_pll_select_o(bus_clock_pll_select), .module_clock_select_o(module_clock_select),
    .filter_tracking_o(ftrk), .clock_monitor_on_o(mon),
    .vco_min_clock_select_o(vmin), .modules_from_pll_o(mpll),
    .monitor_reset_o(mrst), .irq_o(irq));
  // 40 mhz
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task results;
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a spent bound is a hang: count it and stop
  task bound(input integer cnt, input integer lim);
    if (cnt >= lim) begin
      fails++;
      results;
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    n = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    bound(n, 20);
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    cmp(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(`OFF_CTRL, 32'h0000000c);
    cmp(pwr & mon, 1'b1);
    wb(8'h40, 1'b1, 32'hffffffff);
    rdc(8'h40, 32'h0);
    rdc(`OFF_CTRL, 32'h0000000c);
    rdc(`OFF_STAT, 32'h0);
  endtask
  task t_manual;
    cmp(ftrk, 1'b0);
    repeat (8) @(posedge clk_i);
    wb(`OFF_CTRL, 1'b1, 32'h0000000e);
    repeat (2) @(posedge clk_i);
    cmp(ftrk, 1'b1);
    rdc(`OFF_CTRL, 32'h0000000e);
    wb(`OFF_CTRL, 1'b1, 32'h0000010c);
  endtask
  task t_lock;
    near <= 1'b1;
    repeat (6) @(posedge clk_i);
    rdc(`OFF_STAT, 32'h1);
    cmp(irq, 1'b1);
    wb(`OFF_FLAG, 1'b1, 32'h1);
    repeat (2) @(posedge clk_i);
    cmp(irq, 1'b0);
    near <= 1'b0;
    repeat (6) @(posedge clk_i);
    cmp(irq, 1'b1);
    rdc(`OFF_STAT, 32'h0);
    wb(`OFF_FLAG, 1'b1, 32'h1);
    rdc(`OFF_FLAG, 32'h0);
  endtask
  task t_auto;
    wb(`OFF_CTRL, 1'b1, 32'h0000000d);
    near <= 1'b1;
    repeat (6) @(posedge clk_i);
    cmp(ftrk, 1'b1);
    rdc(`OFF_STAT, 32'h5);
    wb(`OFF_CTRL, 1'b1, 32'h0000000d);
    cmp(ftrk, 1'b1);
    near <= 1'b0;
    repeat (6) @(posedge clk_i);
    cmp(ftrk, 1'b0);
    wb(`OFF_FLAG, 1'b1, 32'h3);
  endtask
  task t_limp;
    wb(`OFF_CTRL, 1'b1, 32'h000002cd);
    lost <= 1'b1;
    n = 0;
    while (vmin !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    bound(n, 20);
    cmp({pwr, bus_clock_pll_select, module_clock_select, mpll}, 4'hd);
    rdc(`OFF_STAT, 32'h2);
    cmp(irq, 1'b1);
    wb(`OFF_FLAG, 1'b1, 32'h2);
    wb(`OFF_CTRL, 1'b1, 32'h00000285);
    repeat (2) @(posedge clk_i);
    cmp({mon, bus_clock_pll_select}, 2'h3);
    lost <= 1'b0;
    n = 0;
    while (vmin !== 1'b0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    bound(n, 40);
    cmp(n <= (1 << CW) + 6, 1'b1);
    repeat (2) @(posedge clk_i);
    cmp({mon, bus_clock_pll_select, module_clock_select}, 3'h1);
    rdc(`OFF_FLAG, 32'h2);
  endtask
  task t_noreset;
    wb(`OFF_CTRL, 1'b1, 32'h00000024);
    lost <= 1'b1;
    repeat (8) @(posedge clk_i);
    cmp(mrst, 1'b0);
    wb(`OFF_CTRL, 1'b1, 32'h00000034);
    repeat (6) @(posedge clk_i);
    cmp({mrst, vmin}, 2'h2);
    lost <= 1'b0;
    repeat (6) @(posedge clk_i);
    cmp(mrst, 1'b0);
    // no pll supply: limp-home unavailable, loss resets instead
    wb(`OFF_CTRL, 1'b1, 32'h0000000c);
    sup <= 1'b0;
    lost <= 1'b1;
    repeat (6) @(posedge clk_i);
    cmp({mrst, vmin}, 2'h2);
    lost <= 1'b0;
    repeat (6) @(posedge clk_i);
    sup <= 1'b1;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_manual;
    t_lock;
    t_auto;
    t_limp;
    t_noreset;
    results;
  end
endmodule // pll_lhm_ctrl_bench

// file: verification/pll_lhm_ctrl_chk.sv
// port-level assertions for the pll/limp-home control block
`timescale 1ns/1ps
module pll_lhm_ctrl_chk (
  // system and bus
  input logic clk_i,
  input logic rst_i,
  input logic cyc_i,
  input logic stb_i,
  input logic ack_o,
  // monitor side
  input logic pll_supply_i,
  input logic ext_clk_present_i,
  // clock control
  input logic pll_power_on_o,
  input logic bus_clock_pll_select_o,
  input logic module_clock_select_o,
  input logic clock_monitor_on_o,
  input logic vco_min_clock_select_o,
  input logic modules_from_pll_o,
  input logic monitor_reset_o
);
  // one domain, so one clock and one reset for all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("bad ack");
  property p_lh_force;
    vco_min_clock_select_o |-> pll_power_on_o && bus_clock_pll_select_o
      && !module_clock_select_o;
  endproperty
  a_lh_force: assert property (p_lh_force) else $error("no force");
  property p_lh_monitor;
    vco_min_clock_select_o |-> clock_monitor_on_o;
  endproperty
  a_lh_monitor: assert property (p_lh_monitor) else $error("mon");
  property p_lh_modules;
    vco_min_clock_select_o |-> modules_from_pll_o;
  endproperty
  a_lh_modules: assert property (p_lh_modules) else $error("mod");
  property p_loss_reset;
    monitor_reset_o |-> clock_monitor_on_o && !vco_min_clock_select_o;
  endproperty
  a_loss_reset: assert property (p_loss_reset) else $error("rst");
  property p_supply;
    $rose(vco_min_clock_select_o) |-> $past(pll_supply_i, 4);
  endproperty
  a_supply: assert property (p_supply) else $error("supply");
  // exit only once the monitor has seen the clock back for a while
  property p_exit;
    $fell(vco_min_clock_select_o) |-> $past(ext_clk_present_i, 4);
  endproperty
  a_exit: assert property (p_exit) else $error("early exit");
  property p_reset_val;
    $fell(rst_i) |=> pll_power_on_o && clock_monitor_on_o;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset");
endmodule // pll_lhm_ctrl_chk
////////////////////////////////////////////////////////////////////////////////
bind pll_lhm_ctrl pll_lhm_ctrl_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .pll_supply_i(pll_supply_i), .ext_clk_present_i(ext_clk_present_i),
  .pll_power_on_o(pll_power_on_o),
  .bus_clock_pll_select_o(bus_clock_pll_select_o),
  .module_clock_select_o(module_clock_select_o),
  .clock_monitor_on_o(clock_monitor_on_o),
  .vco_min_clock_select_o(vco_min_clock_select_o),
  .modules_from_pll_o(modules_from_pll_o), .monitor_reset_o(monitor_reset_o));
